//--- logic/supply_integrity_pkg.sv
// Constants and carriers shared by the supply integrity monitor.
// Assumes an APB slave port with 32-bit data and a 12-bit byte address.
package supply_integrity_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CSR_W = 8;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] CTRL_STATUS_OFFSET = 12'h000;
  localparam logic [ADDR_W-1:0] OPTION_VIEW_OFFSET = 12'h004;

  // Field positions of the control/status byte
  localparam int unsigned WDG_FLAG_BIT = 0;
  localparam int unsigned BOR_FLAG_BIT = 4;
  localparam int unsigned WARN_FLAG_BIT = 5;
  localparam int unsigned WARN_IE_BIT = 6;

  // Field positions of the option view word
  localparam int unsigned OPT_EN_BIT = 0;
  localparam int unsigned OPT_LVL_LSB = 1;

  // Brown-out trip levels
  typedef enum logic [1:0]
  {
    LEVEL_LOW = 2'h0,
    LEVEL_MEDIUM = 2'h1,
    LEVEL_HIGH = 2'h2
  } trip_level_t;

  localparam trip_level_t LEVEL_RESET = LEVEL_LOW;
  localparam logic [1:0] SYNC_WARMUP = 2'h2;

  // Control/status byte, most significant bit first
  typedef struct packed
  {
    logic reserved_7;
    logic warn_ie;
    logic warn_flag;
    logic bor_flag;
    logic [2:0] reserved_3_1;
    logic wdg_flag;
  } csr_t;

  localparam csr_t CSR_RESET = 8'h00;

  // Option-byte settings as caught after reset
  typedef struct packed
  {
    trip_level_t level;
    logic enable;
  } option_t;

  localparam option_t OPTION_RESET = 3'h0;

endpackage : supply_integrity_pkg

//--- logic/supply_integrity_monitor.sv
// Supply integrity monitor: brown-out static reset, supply warning flag
// and interrupt, reset cause flags, behind an APB register slave.
// Assumes comparator and option inputs are asynchronous; watchdog reset,
// reset-sequence, halt, wait, mask and acknowledge inputs come from pclk logic.
`timescale 1ns/1ns
`default_nettype none

// Operation
// - Brown-out holds reset, pin driven low
// - Trip level chosen from option setting
// - Option setting includes or excludes detector
// - Warning flag at bit 5, read-only
// - Warning works only with detector enabled
// - Every flag toggle raises request when enabled
// - Pending cleared on service routine entry
// - Flag follows comparator, hardware only
// - No interrupt for crossing during reset delay
// - Early enable gives two interrupts
// - Late enable gives exactly one interrupt
// - Runs in wait, wakes wait only
// - Halt freezes control/status register
// - Interrupt needs enable and cleared mask
// - Brown-out flag set by hardware, cleared zero
// - Brown-out flag undefined when detector excluded
// - Watchdog flag set, cleared by zero or brown-out
// - Brown-out flag kept through other resets
// - Software sets enable, 1 enables
module supply_integrity_monitor
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [supply_integrity_pkg::ADDR_W-1:0] paddr,
  input wire logic [supply_integrity_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [supply_integrity_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic opt_detector_enable,
  input wire logic [1:0] opt_trip_level,
  input wire logic brownout_below_async,
  input wire logic warn_below_async,
  input wire logic watchdog_reset_pulse,
  input wire logic reset_delay_busy,
  input wire logic halt_mode,
  input wire logic wait_mode,
  input wire logic cpu_irq_masked,
  input wire logic warn_irq_ack,
  output logic detector_enable,
  output logic [1:0] trip_threshold,
  output logic system_reset_n,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  output logic warn_irq,
  output logic wait_wakeup
);

  ////////////////////////////////////////////////////////////////////////
  // Synchronisers

  logic [1:0] brown_sync_q;
  logic [1:0] warn_sync_q;
  logic [1:0] opt_en_sync_q;
  logic [3:0] opt_lvl_sync_q;
  logic [1:0] warmup_q;
  logic [1:0] warmup_d;
  logic opt_loaded_q;
  supply_integrity_pkg::option_t option_q;
  supply_integrity_pkg::option_t option_d;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      brown_sync_q <= 2'h0;
      warn_sync_q <= 2'h0;
      opt_en_sync_q <= 2'h0;
      opt_lvl_sync_q <= 4'h0;
    end
    else
    begin
      brown_sync_q <= {brown_sync_q[0], brownout_below_async};
      warn_sync_q <= {warn_sync_q[0], warn_below_async};
      opt_en_sync_q <= {opt_en_sync_q[0], opt_detector_enable};
      opt_lvl_sync_q <= {opt_lvl_sync_q[1:0], opt_trip_level};
    end
  end

  wire brown_below_s = brown_sync_q[1];
  wire warn_below_s = warn_sync_q[1];

  ////////////////////////////////////////////////////////////////////////
  // Option capture: settings are straps, caught once after the release so
  // that no async reset loads a port value.

  wire opt_capture = !opt_loaded_q && (warmup_q == supply_integrity_pkg::SYNC_WARMUP);

  always_comb
  begin
    warmup_d = warmup_q;
    if (warmup_q != supply_integrity_pkg::SYNC_WARMUP)
    begin
      warmup_d = warmup_q + 2'h1;
    end
  end

  always_comb
  begin
    option_d = option_q;
    if (opt_capture)
    begin
      option_d.enable = opt_en_sync_q[1];
      option_d.level = supply_integrity_pkg::trip_level_t'(opt_lvl_sync_q[3:2]);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      warmup_q <= 2'h0;
      opt_loaded_q <= 1'b0;
      option_q <= supply_integrity_pkg::OPTION_RESET;
    end
    else
    begin
      warmup_q <= warmup_d;
      opt_loaded_q <= opt_loaded_q | opt_capture;
      option_q <= option_d;
    end
  end

  assign trip_threshold = option_q.level;
  // detector on or off as a whole
  assign detector_enable = option_q.enable;

  ////////////////////////////////////////////////////////////////////////
  // Static reset. Until the options are caught the device is held in
  // reset as well, which costs a few cycles but never runs unsupervised.

  wire brown_active = option_q.enable && brown_below_s;
  logic hold_reset_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hold_reset_q <= 1'b1;
    end
    else
    begin
      hold_reset_q <= brown_active || !opt_loaded_q;
    end
  end

  assign system_reset_n = !hold_reset_q;
  assign reset_pin_oe = hold_reset_q;
  assign reset_pin_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // APB decode. Zero wait states; unmapped addresses answer with error.

  wire access = psel && penable;
  wire hit_csr = (paddr == supply_integrity_pkg::CTRL_STATUS_OFFSET);
  wire hit_opt = (paddr == supply_integrity_pkg::OPTION_VIEW_OFFSET);
  wire mapped = hit_csr || hit_opt;
  wire csr_write = access && pwrite && hit_csr && pstrb[0] && !halt_mode;

  function automatic logic cleared_by(input logic [supply_integrity_pkg::DATA_W-1:0] data,
                                      input int unsigned pos);
    cleared_by = !data[pos];
  endfunction : cleared_by

  ////////////////////////////////////////////////////////////////////////
  // Control/status register

  supply_integrity_pkg::csr_t csr_q;
  supply_integrity_pkg::csr_t csr_d;
  logic prev_flag_q;
  logic pending_q;
  logic pending_d;

  wire warn_live = option_q.enable && warn_below_s;
  wire flag_toggle = (warn_live != prev_flag_q);
  wire ie_new = pwdata[supply_integrity_pkg::WARN_IE_BIT];
  wire ie_rise = csr_write && ie_new && !csr_q.warn_ie;
  // no request while reset sequence runs
  wire dev_in_reset = hold_reset_q || reset_delay_busy;

  always_comb
  begin
    csr_d = csr_q;
    if (csr_write)
    begin
      csr_d.warn_ie = ie_new;
      if (cleared_by(pwdata, supply_integrity_pkg::BOR_FLAG_BIT))
      begin
        csr_d.bor_flag = 1'b0;
      end
      if (cleared_by(pwdata, supply_integrity_pkg::WDG_FLAG_BIT))
      begin
        csr_d.wdg_flag = 1'b0;
      end
    end
    csr_d.warn_flag = warn_live;
    if (watchdog_reset_pulse)
    begin
      csr_d.wdg_flag = 1'b1;
    end
    // brown-out flag untouched by other resets
    if (brown_active)
    begin
      csr_d.bor_flag = 1'b1;
      csr_d.wdg_flag = 1'b0;
    end
    // flag left as is when excluded
    if (dev_in_reset)
    begin
      csr_d.warn_ie = 1'b0;
    end
    if (halt_mode)
    begin
      csr_d = csr_q;
    end
    csr_d.reserved_7 = 1'b0;
    csr_d.reserved_3_1 = 3'h0;
  end

  always_comb
  begin
    pending_d = pending_q;
    if (warn_irq_ack)
    begin
      pending_d = 1'b0;
    end
    // late enable gives only the enabling one
    if ((csr_q.warn_ie && flag_toggle) || ie_rise)
    begin
      pending_d = 1'b1;
    end
    if (dev_in_reset || !option_q.enable)
    begin
      pending_d = 1'b0;
    end
    if (halt_mode)
    begin
      pending_d = pending_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      csr_q <= supply_integrity_pkg::CSR_RESET;
      prev_flag_q <= 1'b0;
      pending_q <= 1'b0;
    end
    else
    begin
      csr_q <= csr_d;
      prev_flag_q <= halt_mode ? prev_flag_q : warn_live;
      pending_q <= pending_d;
    end
  end

  assign warn_irq = pending_q && csr_q.warn_ie && !cpu_irq_masked;
  // wakes from wait, never from halt
  assign wait_wakeup = warn_irq && wait_mode && !halt_mode;

  ////////////////////////////////////////////////////////////////////////
  // Read data

  logic [supply_integrity_pkg::DATA_W-1:0] rdata_q;
  logic [supply_integrity_pkg::DATA_W-1:0] rdata_d;
  logic err_q;

  always_comb
  begin
    rdata_d = '0;
    if (hit_csr)
    begin
      rdata_d[supply_integrity_pkg::CSR_W-1:0] = csr_q;
    end
    else if (hit_opt)
    begin
      rdata_d[supply_integrity_pkg::OPT_EN_BIT] = option_q.enable;
      rdata_d[supply_integrity_pkg::OPT_LVL_LSB +: 2] = option_q.level;
    end
  end

  // Read data is registered in the setup cycle so the access phase
  // presents it from a flip-flop with no wait state.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_q <= '0;
      err_q <= 1'b0;
    end
    else
    begin
      rdata_q <= (psel && !penable && !pwrite) ? rdata_d : rdata_q;
      err_q <= psel && !penable && !mapped;
    end
  end

  assign prdata = rdata_q;
  assign pready = 1'b1;
  assign pslverr = access && err_q;

endmodule : supply_integrity_monitor

`default_nettype wire

//--- tb/supply_analog_model.sv
// Far side model: supply comparators and the reset pin.
// Assumes the bench commands both comparator levels.
`timescale 1ns/1ns
`default_nettype none
module supply_analog_model
(
  input wire logic brown_cmd,
  input wire logic warn_cmd,
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic brownout_below_async,
  output logic warn_below_async,
  output logic pin_level
);
  assign brownout_below_async = brown_cmd;
  assign warn_below_async = warn_cmd;
  // Pull-up wins once the pin is released
  assign pin_level = pin_oe ? pin_out : 1'b1;
endmodule : supply_analog_model
`default_nettype wire

//--- tb/supply_integrity_monitor_props.sv
// Port checker of the supply integrity monitor.
// Assumes it is bound to the monitor.
`timescale 1ns/1ns
`default_nettype none
module supply_integrity_monitor_props
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic brownout_below_async,
  input wire logic warn_below_async,
  input wire logic reset_delay_busy,
  input wire logic halt_mode,
  input wire logic wait_mode,
  input wire logic cpu_irq_masked,
  input wire logic warn_irq_ack,
  input wire logic detector_enable,
  input wire logic system_reset_n,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  input wire logic warn_irq,
  input wire logic wait_wakeup
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_pin;
    brownout_below_async && detector_enable |-> ##[1:4] reset_pin_oe && !system_reset_n;
  endproperty
  a_pin: assert property (p_pin) else $error("no brown-out reset");
  property p_low;
    reset_pin_oe |-> !reset_pin_out;
  endproperty
  a_low: assert property (p_low) else $error("pin driven high");
  property p_mask;
    warn_irq |-> !cpu_irq_masked;
  endproperty
  a_mask: assert property (p_mask) else $error("irq while masked");
  property p_wake;
    warn_irq && wait_mode && !halt_mode |-> wait_wakeup;
  endproperty
  a_wake: assert property (p_wake) else $error("no wait wakeup");
  property p_halt;
    halt_mode |-> !wait_wakeup;
  endproperty
  a_halt: assert property (p_halt) else $error("halt wakeup");
  property p_off;
    !detector_enable |-> !warn_irq;
  endproperty
  a_off: assert property (p_off) else $error("irq with detector off");
  property p_delay;
    reset_delay_busy |=> !warn_irq;
  endproperty
  a_delay: assert property (p_delay) else $error("irq in reset delay");
  // Quiet comparator so no new toggle races the ack
  property p_ack;
    warn_irq_ack && !halt_mode && !psel && $stable(warn_below_async)
      && $past(warn_below_async, 3) == warn_below_async |=> !warn_irq;
  endproperty
  a_ack: assert property (p_ack) else $error("pending not cleared");
endmodule : supply_integrity_monitor_props
bind supply_integrity_monitor supply_integrity_monitor_props u_props (.*);
`default_nettype wire

//--- tb/supply_integrity_monitor_tb_top.sv
// Bench of the supply integrity monitor.
// Assumes the analogue model and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module supply_integrity_monitor_tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [supply_integrity_pkg::ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic [1:0] trip_threshold, opt_trip_level = 2'h2;
  logic pready, pslverr, detector_enable, system_reset_n, reset_pin_out, reset_pin_oe;
  logic warn_irq, wait_wakeup, err, pin_level, brown_cmd = 0, warn_cmd = 0;
  logic opt_detector_enable = 1, watchdog_reset_pulse = 0, reset_delay_busy = 0;
  logic halt_mode = 0, wait_mode = 0, cpu_irq_masked = 0, warn_irq_ack = 0;
  logic brownout_below_async, warn_below_async;
  int num_errors = 0, comparisons = 0, cycles = 0;
  always #2 pclk = ~pclk;
  supply_integrity_monitor u_supply_integrity_monitor (.*);
  supply_analog_model u_supply_analog_model
  (
    .brown_cmd(brown_cmd),
    .warn_cmd(warn_cmd),
    .pin_out(reset_pin_out),
    .pin_oe(reset_pin_oe),
    .brownout_below_async(brownout_below_async),
    .warn_below_async(warn_below_async),
    .pin_level(pin_level)
  );
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // Request stands until pready is sampled high at a rising edge
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic rd_csr(string what, logic [31:0] exp);
    apb(0, 12'h000, 0);
    check(what, exp, rd);
  endtask : rd_csr
  task automatic ack;
    @(posedge pclk);
    warn_irq_ack <= 1;
    @(posedge pclk);
    warn_irq_ack <= 0;
    @(negedge pclk);
    check("ack", 0, warn_irq);
  endtask : ack
  task automatic wdg;
    @(posedge pclk);
    watchdog_reset_pulse <= 1;
    @(posedge pclk);
    watchdog_reset_pulse <= 0;
  endtask : wdg
  task automatic wait_run;
    for (int i = 0; i < 20 && system_reset_n !== 1'b1; i++)
      @(negedge pclk);
    check("run", 1, system_reset_n);
  endtask : wait_run
  task automatic t_regs;
    rd_csr("reset", 0);
    apb(0, 12'h004, 0);
    check("options", 32'h0000_0005, rd);
    check("level out", 2, trip_threshold);
    check("detector out", 1, detector_enable);
    apb(0, 12'h008, 0);
    check("unmapped", 1, err);
    apb(1, 12'h000, 32'h0000_0071);
    @(negedge pclk);
    check("irq on", 1, warn_irq);
    rd_csr("ro bits", 32'h0000_0040);
    ack();
    $display("t_regs end");
  endtask : t_regs
  task automatic t_warn;
    @(posedge pclk);
    warn_cmd <= 1;
    repeat (6) @(negedge pclk);
    check("irq fall", 1, warn_irq);
    rd_csr("flag", 32'h0000_0060);
    ack();
    @(posedge pclk);
    cpu_irq_masked <= 1;
    warn_cmd <= 0;
    repeat (6) @(negedge pclk);
    check("masked", 0, warn_irq);
    @(posedge pclk);
    cpu_irq_masked <= 0;
    wait_mode <= 1;
    repeat (2) @(negedge pclk);
    check("wake", 1, wait_wakeup);
    ack();
    @(posedge pclk);
    halt_mode <= 1;
    apb(1, 12'h000, 0);
    halt_mode <= 0;
    wait_mode <= 0;
    rd_csr("frozen", 32'h0000_0040);
    $display("t_warn end");
  endtask : t_warn
  task automatic t_delay;
    @(posedge pclk);
    reset_delay_busy <= 1;
    warn_cmd <= 1;
    repeat (8) @(posedge pclk);
    warn_cmd <= 0;
    repeat (8) @(posedge pclk);
    reset_delay_busy <= 0;
    repeat (4) @(negedge pclk);
    check("no irq", 0, warn_irq);
    $display("t_delay end");
  endtask : t_delay
  task automatic t_brown;
    wdg();
    // detector is enabled, so the brown-out flag is usable
    rd_csr("wdg", 1);
    brown_cmd <= 1;
    repeat (6) @(negedge pclk);
    check("pin", 0, pin_level);
    @(posedge pclk);
    brown_cmd <= 0;
    wait_run();
    rd_csr("bor", 32'h0000_0010);
    wdg();
    rd_csr("kept", 32'h0000_0011);
    apb(1, 12'h000, 0);
    rd_csr("clear", 0);
    $display("t_brown end");
  endtask : t_brown
  task automatic print_verdict;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    wait_run();
    t_regs();
    t_warn();
    t_delay();
    t_brown();
    print_verdict();
  end
endmodule : supply_integrity_monitor_tb_top
`default_nettype wire
